// [mil_pkg.sv]
// Purpose: Shared constants and types of the microcontroller interrupt logic.
// Assumes: Register indices are kept as printed; the APB byte address is four times the index.
// Notes: Field positions follow the interrupt control register layout.
`default_nettype none
package mil_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_INT_CTRL = 8'h0b;
  localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PERIPH_EN = 8'h8c;

  // Byte address of a register on the APB side.
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
  localparam int TMR_EN_BIT = 5;
  localparam int EXT_EN_BIT = 4;
  localparam int PORT_EN_BIT = 3;
  localparam int TMR_FLAG_BIT = 2;
  localparam int EXT_FLAG_BIT = 1;
  localparam int PORT_FLAG_BIT = 0;
  localparam int CMP_BIT = 6;
  localparam int EDGE_SEL_BIT = 6;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_PERIPH = 8'h00;
  localparam logic [7:0] PERIPH_MASK = 8'h40;
  localparam int NUM_SOURCES = 4;

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  localparam int PC_W = 13;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } mil_phase_t;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_SYNC = 2'b01,
    SQ_PUSH = 2'b11,
    SQ_VECT = 2'b10
  } mil_seq_t;

endpackage
`default_nettype wire

// [mil_top.sv]
// Purpose: Interrupt flags, enables, vectoring and wake-up for a small 8-bit core.
// Assumes: 10 MHz ref_clk; one Q phase per Q_CLKS clocks; core signals on the same clock.
// Notes: Registers are reached over APB with zero wait states.
//
// How it works
// - Four sources: external edge pin, timer overflow, port change, comparator.
// - Global enable bit 7 passes unmasked requests when set, blocks all when clear.
// - Every reset clears the global enable.
// - Return-from-interrupt instruction sets the global enable again.
// - Taking a request clears global enable, pushes return address, vectors to 0004h.
// - Source flags set on their event regardless of any enable bit.
// - Clearing global enable ignores next-cycle requests and inserts a no-operation.
// - Latency three cycles synchronous, three or four asynchronous, instruction length irrelevant.
// - Edge select bit 6 of option register picks rising or falling pin edge.
// - Valid pin edge sets control bit 1; enable bit 4 gates it.
// - Pin request wakes from sleep if enabled; global enable decides vectoring.
// - Timer rollover sets control bit 2; enable bit 5 gates it.
// - Upper port pin change sets control bit 0, gated by enable bit 3.
// - A change coinciding with a port read at Q2 may be missed.
// - Comparator flag and enable in bit 6 of peripheral registers, gated by group enable; cpu_wake ignores the group enable.
// - Pin flag may be set only during Q4 through Q1 phases.
// - Only the return address is saved on entry.
// - Any individually enabled request wakes from sleep whatever the global enable.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module mil_top #(
  parameter int Q_CLKS = 1
) (
  input wire logic ref_clk, // System clock, 10 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [mil_pkg::ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic ext_irq_pin, // External interrupt pin, asynchronous.
  input wire logic [3:0] port_b_pins, // Upper four port pins, asynchronous.
  input wire logic port_read, // Core reads the port, one-cycle pulse.
  input wire logic timer_overflow, // Timer register rolled over, one-cycle pulse.
  input wire logic comparator_event, // Comparator output changed, one-cycle pulse.
  input wire logic return_from_irq_instr, // Core executes return from interrupt, pulse.
  input wire logic sleep_active, // Core is asleep.
  input wire logic [mil_pkg::PC_W-1:0] core_pc, // Address of the next instruction.
  output logic [1:0] q_phase, // Current instruction-cycle phase.
  output logic cycle_start, // Pulse on the clock that begins Q1.
  output logic cpu_wake, // Level: wake the core from sleep.
  output logic irq_request, // Level: vectoring request before sequencing.
  output logic nop_insert, // Pulse: core executes a forced no-operation.
  output logic stack_push, // Pulse: push return address.
  output logic [mil_pkg::PC_W-1:0] stack_data, // Return address to push.
  output logic vector_load, // Pulse: load program counter with vector.
  output logic [mil_pkg::PC_W-1:0] vector_addr, // Vector address.
  output logic global_irq_enable // Level: current global enable.
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (Q_CLKS < 1 || Q_CLKS > 255) begin : g_bad_q_clks
    $error("Q_CLKS must be between 1 and 255.");
  end

  // ----------------------------------------------------------------
  // Phase generator
  // ----------------------------------------------------------------
  logic [7:0] div_ff;
  logic q_tick;
  mil_pkg::mil_phase_t phase_ff;
  mil_pkg::mil_phase_t nxt_phase;
  logic q1_tick;
  logic q4q1_window;

  assign q_tick = (div_ff == 8'(Q_CLKS - 1));

  always_ff @(posedge ref_clk) begin
    if (rst || q_tick) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  always_comb begin
    case (phase_ff)
      mil_pkg::PH_Q1: nxt_phase = mil_pkg::PH_Q2;
      mil_pkg::PH_Q2: nxt_phase = mil_pkg::PH_Q3;
      mil_pkg::PH_Q3: nxt_phase = mil_pkg::PH_Q4;
      default: nxt_phase = mil_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_ff <= mil_pkg::PH_Q1;
    end else if (q_tick) begin
      phase_ff <= nxt_phase;
    end
  end

  // The Q1 tick ends Q1 and starts the instruction cycle's decisions.
  assign q1_tick = q_tick && (phase_ff == mil_pkg::PH_Q1);
  assign q4q1_window = q_tick && (phase_ff == mil_pkg::PH_Q4 || phase_ff == mil_pkg::PH_Q1);
  assign q_phase = phase_ff;
  assign cycle_start = q_tick && (phase_ff == mil_pkg::PH_Q4);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_meta_ff;
  logic [4:0] pin_sync_ff;
  logic ext_prev_ff;

  // The chain runs through reset, so a pin resting high gives no false edge on release.
  always_ff @(posedge ref_clk) begin
    pin_meta_ff <= {port_b_pins, ext_irq_pin};
    pin_sync_ff <= pin_meta_ff;
  end

  always_ff @(posedge ref_clk) begin
    ext_prev_ff <= pin_sync_ff[0];
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] int_ctrl_ff;
  logic [7:0] option_ff;
  logic periph_flag_ff;
  logic periph_en_ff;
  logic [3:0] port_latch_ff;
  logic ext_edge_ff;

  // Register decode, one-hot: control, peripheral flags, option, peripheral enables.
  function automatic logic [3:0] reg_sel(input logic [mil_pkg::ADDR_W-1:0] addr);
    if (addr == mil_pkg::byte_addr(mil_pkg::IDX_INT_CTRL)) begin
      return 4'h1;
    end else if (addr == mil_pkg::byte_addr(mil_pkg::IDX_PERIPH_FLAGS)) begin
      return 4'h2;
    end else if (addr == mil_pkg::byte_addr(mil_pkg::IDX_OPTION)) begin
      return 4'h4;
    end else if (addr == mil_pkg::byte_addr(mil_pkg::IDX_PERIPH_EN)) begin
      return 4'h8;
    end else begin
      return 4'h0;
    end
  endfunction

  logic wr_en;
  logic [3:0] wr_sel;
  logic [3:0] rd_sel;
  logic [7:0] wdata;

  assign wr_en = psel && penable && pwrite;
  assign wr_sel = wr_en ? reg_sel(paddr) : 4'h0;
  assign rd_sel = reg_sel(paddr);
  assign wdata = pwdata[7:0];

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic edge_seen;
  logic port_mismatch;
  logic sec_tmr;
  logic sec_ext;
  logic sec_port;

  assign edge_seen = option_ff[mil_pkg::EDGE_SEL_BIT] ?
                     (pin_sync_ff[0] && !ext_prev_ff) : (!pin_sync_ff[0] && ext_prev_ff);

  // A pin edge waits here until the Q4-Q1 window lets it into the flag.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_edge_ff <= 1'b0;
    end else if (edge_seen) begin
      ext_edge_ff <= 1'b1;
    end else if (q4q1_window) begin
      ext_edge_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Reset takes the present pins, so a port resting high raises no flag.
      port_latch_ff <= pin_sync_ff[4:1];
    end else if (port_read && phase_ff == mil_pkg::PH_Q2) begin
      port_latch_ff <= pin_sync_ff[4:1];
    end
  end

  assign port_mismatch = (pin_sync_ff[4:1] != port_latch_ff) &&
                         !(port_read && phase_ff == mil_pkg::PH_Q2);

  assign sec_tmr = timer_overflow;
  assign sec_ext = ext_edge_ff && q4q1_window;
  assign sec_port = port_mismatch;

  // ----------------------------------------------------------------
  // Sequencer signals
  // ----------------------------------------------------------------
  mil_pkg::mil_seq_t seq_ff;
  mil_pkg::mil_seq_t nxt_seq;
  logic hold_ff;
  logic take_clear;
  logic sw_gie_clear;

  assign take_clear = q1_tick && (seq_ff == mil_pkg::SQ_SYNC) && int_ctrl_ff[mil_pkg::GIE_BIT];
  assign sw_gie_clear = wr_sel[0] && !wdata[mil_pkg::GIE_BIT] &&
                        int_ctrl_ff[mil_pkg::GIE_BIT];

  // ----------------------------------------------------------------
  // Interrupt control register
  // ----------------------------------------------------------------
  logic [7:0] nxt_int_ctrl;
  logic [2:0] flag_set;

  assign flag_set = {sec_tmr, sec_ext, sec_port};

  always_comb begin
    nxt_int_ctrl = int_ctrl_ff;
    if (wr_sel[0]) begin
      nxt_int_ctrl = wdata;
    end
    if (take_clear) begin
      nxt_int_ctrl[mil_pkg::GIE_BIT] = 1'b0;
    end
    if (return_from_irq_instr) begin
      nxt_int_ctrl[mil_pkg::GIE_BIT] = 1'b1;
    end
    nxt_int_ctrl[mil_pkg::TMR_FLAG_BIT:mil_pkg::PORT_FLAG_BIT] =
      nxt_int_ctrl[mil_pkg::TMR_FLAG_BIT:mil_pkg::PORT_FLAG_BIT] | flag_set;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_ctrl_ff <= mil_pkg::RST_INT_CTRL;
    end else begin
      int_ctrl_ff <= nxt_int_ctrl;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      option_ff <= mil_pkg::RST_OPTION;
    end else if (wr_sel[2]) begin
      option_ff <= wdata;
    end
  end

  // comparator flag in peripheral bit 6
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      periph_flag_ff <= 1'b0;
    end else if (comparator_event) begin
      periph_flag_ff <= 1'b1;
    end else if (wr_sel[1]) begin
      periph_flag_ff <= wdata[mil_pkg::CMP_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      periph_en_ff <= 1'b0;
    end else if (wr_sel[3]) begin
      periph_en_ff <= wdata[mil_pkg::CMP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Request combination
  // ----------------------------------------------------------------
  logic [mil_pkg::NUM_SOURCES-1:0] src_flag;
  logic [mil_pkg::NUM_SOURCES-1:0] src_en;
  logic [mil_pkg::NUM_SOURCES-1:0] src_req;
  logic any_enabled;
  logic group_req;

  assign src_flag = {periph_flag_ff, int_ctrl_ff[mil_pkg::TMR_FLAG_BIT],
                     int_ctrl_ff[mil_pkg::EXT_FLAG_BIT], int_ctrl_ff[mil_pkg::PORT_FLAG_BIT]};
  assign src_en = {periph_en_ff, int_ctrl_ff[mil_pkg::TMR_EN_BIT],
                   int_ctrl_ff[mil_pkg::EXT_EN_BIT], int_ctrl_ff[mil_pkg::PORT_EN_BIT]};

  for (genvar i = 0; i < mil_pkg::NUM_SOURCES; i++) begin : g_src
    assign src_req[i] = src_flag[i] && src_en[i];
  end

  assign any_enabled = |src_req;
  assign group_req = (|src_req[2:0]) ||
                     (src_req[3] && int_ctrl_ff[mil_pkg::PERIPHERAL_GROUP_ENABLE_BIT]);
  assign irq_request = group_req && int_ctrl_ff[mil_pkg::GIE_BIT];
  // any enabled source flag wakes the core
  assign cpu_wake = sleep_active && any_enabled;
  assign global_irq_enable = int_ctrl_ff[mil_pkg::GIE_BIT];

  // ----------------------------------------------------------------
  // No-operation slot after a software clear
  // ----------------------------------------------------------------
  // hold until the next Q1 tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_ff <= 1'b0;
    end else if (sw_gie_clear) begin
      hold_ff <= 1'b1;
    end else if (q1_tick) begin
      hold_ff <= 1'b0;
    end
  end

  assign nop_insert = hold_ff && q1_tick;

  // ----------------------------------------------------------------
  // Entry sequencer
  // ----------------------------------------------------------------
  // three-cycle path; SQ_SYNC returns to SQ_IDLE if global enable is clear or hold_ff is set
  always_comb begin
    nxt_seq = seq_ff;
    case (seq_ff)
      mil_pkg::SQ_IDLE: begin
        if (irq_request && !hold_ff && !sleep_active) begin
          nxt_seq = mil_pkg::SQ_SYNC;
        end
      end
      mil_pkg::SQ_SYNC: begin
        if (int_ctrl_ff[mil_pkg::GIE_BIT] && !hold_ff) begin
          nxt_seq = mil_pkg::SQ_PUSH;
        end else begin
          nxt_seq = mil_pkg::SQ_IDLE;
        end
      end
      mil_pkg::SQ_PUSH: nxt_seq = mil_pkg::SQ_VECT;
      default: nxt_seq = mil_pkg::SQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seq_ff <= mil_pkg::SQ_IDLE;
    end else if (q1_tick) begin
      seq_ff <= nxt_seq;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stack_push <= 1'b0;
      stack_data <= mil_pkg::PC_RESET;
    end else begin
      stack_push <= take_clear;
      if (take_clear) begin
        stack_data <= core_pc;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vector_load <= 1'b0;
      vector_addr <= mil_pkg::PC_RESET;
    end else begin
      vector_load <= q1_tick && (seq_ff == mil_pkg::SQ_PUSH);
      vector_addr <= mil_pkg::VECTOR_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    case (rd_sel)
      4'h1: rd_byte = int_ctrl_ff;
      4'h2: rd_byte = periph_flag_ff ? mil_pkg::PERIPH_MASK : 8'h00;
      4'h4: rd_byte = option_ff;
      4'h8: rd_byte = periph_en_ff ? mil_pkg::PERIPH_MASK : 8'h00;
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data and error are captured in the setup cycle for a zero-wait access.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
      pslverr <= (rd_sel == 4'h0);
    end
  end

  assign pready = 1'b1;

endmodule

`default_nettype wire

// [mil_core_model.sv]
// Purpose: Behavioural core sequencer facing the interrupt logic.
// Assumes: Same clock as the interrupt logic; ret_req is a one-clock bench command.
// Notes: The stack is one deep, which is enough for unnested service.
`timescale 1ns/10ps
`default_nettype none
module mil_core_model (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Synchronous reset.
  input wire logic cycle_start, // Start of an instruction cycle.
  input wire logic stack_push, // Push return address.
  input wire logic [mil_pkg::PC_W-1:0] stack_data, // Address pushed.
  input wire logic vector_load, // Load the vector.
  input wire logic [mil_pkg::PC_W-1:0] vector_addr, // Vector address.
  input wire logic ret_req, // Bench asks for a return.
  output logic return_from_irq_instr, // Return pulse.
  output logic [mil_pkg::PC_W-1:0] core_pc // Next instruction address.
);
  logic [mil_pkg::PC_W-1:0] stack_ff;
  logic [mil_pkg::PC_W-1:0] pc_ff;
  logic ret_ff;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stack_ff <= '0;
    end else if (stack_push) begin
      stack_ff <= stack_data;
    end
  end
  always_ff @(posedge ref_clk) begin
    ret_ff <= !rst && ret_req;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pc_ff <= '0;
    end else if (vector_load) begin
      pc_ff <= vector_addr;
    end else if (ret_ff) begin
      pc_ff <= stack_ff;
    end else if (cycle_start) begin
      pc_ff <= pc_ff + 13'h0001;
    end
  end
  assign core_pc = pc_ff;
  assign return_from_irq_instr = ret_ff;
endmodule
`default_nettype wire

// [mil_assertions.sv]
// Purpose: Concurrent checks on the ports of the interrupt logic.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound into every instance of the top module.
`timescale 1ns/10ps
`default_nettype none
module mil_chk (
  input wire logic ref_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access.
  input wire logic [mil_pkg::ADDR_W-1:0] paddr, // APB address.
  input wire logic pslverr, // APB error.
  input wire logic return_from_irq_instr, // Return pulse.
  input wire logic [mil_pkg::PC_W-1:0] core_pc, // Core address.
  input wire logic stack_push, // Push pulse.
  input wire logic [mil_pkg::PC_W-1:0] stack_data, // Pushed address.
  input wire logic vector_load, // Vector pulse.
  input wire logic [mil_pkg::PC_W-1:0] vector_addr, // Vector address.
  input wire logic global_irq_enable, // Global enable.
  input wire logic irq_request, // Vector request.
  input wire logic nop_insert, // Forced no-operation.
  input wire logic cycle_start, // Cycle start.
  input wire logic [1:0] q_phase, // Phase.
  input wire logic cpu_wake // Wake.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_rst_gie: assert property ($fell(rst) |-> !global_irq_enable)
    else $error("global enable set after reset");
  a_vec_addr: assert property (vector_load |-> vector_addr == 13'h0004)
    else $error("wrong vector address");
  a_push_gie: assert property (stack_push |-> !global_irq_enable)
    else $error("global enable kept at entry");
  a_push_vect: assert property (stack_push |-> ##[1:1000] vector_load)
    else $error("vector load missing after push");
  a_push_data: assert property (stack_push |-> stack_data == $past(core_pc))
    else $error("wrong return address pushed");
  a_ret_gie: assert property (return_from_irq_instr |=> global_irq_enable)
    else $error("return did not set global enable");
  a_req_gie: assert property (irq_request |-> global_irq_enable)
    else $error("request without global enable");
  a_nop_gie: assert property (nop_insert |-> !global_irq_enable && !vector_load)
    else $error("no-operation while enabled");
  a_cyc_phase: assert property (cycle_start |=> q_phase == mil_pkg::PH_Q1)
    else $error("cycle start not followed by first phase");
  a_bad_err: assert property (psel && penable && !(paddr inside
    {12'h02c, 12'h030, 12'h204, 12'h230}) |-> pslverr)
    else $error("unmapped access without error");
  c_vector: cover property (vector_load);
  c_nop: cover property (nop_insert);
  c_wake: cover property (cpu_wake);
endmodule
bind mil_top mil_chk chk_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .paddr(paddr), .pslverr(pslverr), .return_from_irq_instr(return_from_irq_instr),
  .core_pc(core_pc), .stack_push(stack_push), .stack_data(stack_data),
  .vector_load(vector_load), .vector_addr(vector_addr), .global_irq_enable(global_irq_enable),
  .irq_request(irq_request), .nop_insert(nop_insert), .cycle_start(cycle_start),
  .q_phase(q_phase), .cpu_wake(cpu_wake));
`default_nettype wire

// [mil_interrupt_logic_bench.sv]
// Purpose: Self-checking bench for the interrupt logic with a core model.
// Assumes: Q_CLKS of one, so one phase per clock.
// Notes: Latency is checked within a tolerant window of clocks.
`timescale 1ns/10ps
`default_nettype none
module mcu_interrupt_logic_bench;
  localparam logic [11:0] A_CTL = 12'h02c;
  localparam logic [11:0] A_PF = 12'h030;
  localparam logic [11:0] A_OPT = 12'h204;
  localparam logic [11:0] A_PE = 12'h230;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ext_irq_pin = 1'b0, port_read = 1'b0, timer_overflow = 1'b0, ret_req = 1'b0;
  logic comparator_event = 1'b0, sleep_active = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] port_b_pins = 4'h0;
  logic [1:0] q_phase;
  logic [12:0] core_pc, stack_data, vector_addr;
  logic pready, pslverr, cycle_start, cpu_wake, irq_request, nop_insert, stack_push;
  logic vector_load, global_irq_enable, return_from_irq_instr;
  int miscompares = 0, compares = 0, vec_cnt_ff = 0, nop_cnt_ff = 0;
  mil_top #(.Q_CLKS(1)) dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin(ext_irq_pin), .port_b_pins(port_b_pins),
    .port_read(port_read), .timer_overflow(timer_overflow),
    .comparator_event(comparator_event), .return_from_irq_instr(return_from_irq_instr),
    .sleep_active(sleep_active), .core_pc(core_pc), .q_phase(q_phase),
    .cycle_start(cycle_start), .cpu_wake(cpu_wake), .irq_request(irq_request),
    .nop_insert(nop_insert), .stack_push(stack_push), .stack_data(stack_data),
    .vector_load(vector_load), .vector_addr(vector_addr),
    .global_irq_enable(global_irq_enable));
  mil_core_model core_u (.ref_clk(ref_clk), .rst(rst), .cycle_start(cycle_start),
    .stack_push(stack_push), .stack_data(stack_data), .vector_load(vector_load),
    .vector_addr(vector_addr), .ret_req(ret_req),
    .return_from_irq_instr(return_from_irq_instr), .core_pc(core_pc));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (vector_load === 1'b1) vec_cnt_ff <= vec_cnt_ff + 1;
    if (nop_insert === 1'b1) nop_cnt_ff <= nop_cnt_ff + 1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_vec(output int lat);
    int n;
    n = vec_cnt_ff;
    lat = 0;
    while (vec_cnt_ff == n && lat < 40) begin
      cyc(1);
      lat++;
    end
  endtask
  task automatic t_reset;
    apb(1'b0, A_CTL, 32'h0); chk("control", 32'h00, rd);
    apb(1'b0, A_OPT, 32'h0); chk("option", 32'hff, rd);
    apb(1'b0, A_PF, 32'h0); chk("pflags", 32'h00, rd);
    apb(1'b0, A_PE, 32'h0); chk("penables", 32'h00, rd);
    apb(1'b1, 12'h100, 32'hff); chk("bad error", 32'h1, err);
    apb(1'b0, A_CTL, 32'h0); chk("control kept", 32'h00, rd);
  endtask
  task automatic t_flags;
    timer_overflow <= 1'b1;
    cyc(1);
    timer_overflow <= 1'b0;
    ext_irq_pin <= 1'b1;
    cyc(10);
    apb(1'b0, A_CTL, 32'h0); chk("flags set", 32'h06, rd);
    chk("request off", 32'h0, irq_request);
    apb(1'b1, A_CTL, 32'h0);
    apb(1'b1, A_OPT, 32'hbf);
    ext_irq_pin <= 1'b0;
    cyc(10);
    apb(1'b0, A_CTL, 32'h0); chk("fall edge", 32'h02, rd);
    apb(1'b1, A_CTL, 32'h0);
    ext_irq_pin <= 1'b1;
    cyc(10);
    apb(1'b0, A_CTL, 32'h0); chk("rise ignored", 32'h00, rd);
    apb(1'b1, A_OPT, 32'hff);
    port_b_pins <= 4'h8;
    cyc(10);
    apb(1'b0, A_CTL, 32'h0); chk("port change", 32'h01, rd);
    port_read <= 1'b1;
    cyc(4);
    port_read <= 1'b0;
    comparator_event <= 1'b1;
    cyc(1);
    comparator_event <= 1'b0;
    apb(1'b0, A_PF, 32'h0); chk("comparator", 32'h40, rd);
    apb(1'b1, A_PF, 32'h0);
    apb(1'b1, A_CTL, 32'h0);
  endtask
  task automatic t_vector;
    int lat;
    int n;
    apb(1'b1, A_CTL, 32'ha0);
    timer_overflow <= 1'b1;
    cyc(1);
    timer_overflow <= 1'b0;
    wait_vec(lat);
    chk("latency", 32'h1, lat >= 11 && lat <= 14);
    apb(1'b0, A_CTL, 32'h0); chk("entry", 32'h24, rd);
    apb(1'b1, A_CTL, 32'h20);
    ret_req <= 1'b1;
    cyc(1);
    ret_req <= 1'b0;
    cyc(2);
    apb(1'b0, A_CTL, 32'h0); chk("return", 32'ha0, rd);
    n = vec_cnt_ff;
    cyc(20);
    chk("no reentry", n, vec_cnt_ff);
    apb(1'b1, A_CTL, 32'h0);
  endtask
  task automatic t_periph;
    int lat;
    apb(1'b1, A_PE, 32'h40);
    apb(1'b1, A_CTL, 32'h80);
    comparator_event <= 1'b1;
    cyc(1);
    comparator_event <= 1'b0;
    cyc(8);
    chk("group off", 32'h0, irq_request);
    apb(1'b1, A_CTL, 32'hc0);
    cyc(1);
    chk("group on", 32'h1, irq_request);
    wait_vec(lat);
    chk("comparator vector", 32'h1, lat < 40);
    apb(1'b1, A_PF, 32'h0);
    apb(1'b1, A_PE, 32'h0);
    apb(1'b1, A_CTL, 32'h0);
  endtask
  task automatic t_gie_clear;
    int lat;
    int n;
    int m;
    apb(1'b1, A_CTL, 32'ha0);
    n = vec_cnt_ff;
    m = nop_cnt_ff;
    timer_overflow <= 1'b1;
    cyc(1);
    timer_overflow <= 1'b0;
    apb(1'b1, A_CTL, 32'h24);
    cyc(20);
    chk("aborted", n, vec_cnt_ff);
    chk("nop", 32'h1, nop_cnt_ff > m);
    apb(1'b0, A_CTL, 32'h0); chk("pending", 32'h24, rd);
    apb(1'b1, A_CTL, 32'ha4);
    wait_vec(lat);
    chk("served later", 32'h1, lat < 40);
    apb(1'b1, A_CTL, 32'h0);
  endtask
  task automatic t_sleep;
    int n;
    sleep_active <= 1'b1;
    ext_irq_pin <= 1'b0;
    cyc(10);
    ext_irq_pin <= 1'b1;
    cyc(10);
    apb(1'b0, A_CTL, 32'h0); chk("pin flag", 32'h02, rd);
    chk("no wake", 32'h0, cpu_wake);
    n = vec_cnt_ff;
    apb(1'b1, A_CTL, 32'h12);
    cyc(1);
    chk("wake", 32'h1, cpu_wake);
    cyc(20);
    chk("no branch", n, vec_cnt_ff);
    sleep_active <= 1'b0;
    apb(1'b1, A_CTL, 32'h0);
  endtask
  task automatic t_reset_mid;
    apb(1'b1, A_CTL, 32'h80);
    apb(1'b1, A_OPT, 32'h00);
    rst <= 1'b1;
    cyc(5);
    rst <= 1'b0;
    t_reset;
  endtask
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    miscompares++;
    print_verdict;
  end
  initial begin
    cyc(5);
    rst <= 1'b0;
    t_reset;
    t_flags;
    t_vector;
    t_periph;
    t_gie_clear;
    t_sleep;
    t_reset_mid;
    print_verdict;
  end
endmodule
`default_nettype wire
